// ==== hw/mogw_cfg.svh ====
`ifndef MOGW_CFG_SVH
`define MOGW_CFG_SVH
// What this block does
// - only one data interface active; enabling the other slot turns this one off.
// - ingress disabled stops forwarding LAN-derived stream toward WAN.
// - ingress FEC enable applies recovery; disabled bypasses it.
// - two ingress streams, each own group and source, shared destination port.
// - single mode processes only primary-selected stream, never switches.
// - dual mode starts on primary, switches to other stream on failure.
// - revertive mode switches to healthy stream in either direction.
// - non-revertive never switches back automatically; user command returns to primary.
// - switchover only after failure persists for timeout, in 100 ms steps.
// - egress disabled sends no media packets; enabled sends continuously.
// - egress FEC enabled adds FEC packets; disabled produces none.
// - FEC length 1..20, depth 4..20, product at most 100.
// - egress headers use configured group, source port, destination port.
// - media to destination port, FEC packets to destination port plus two.
// - management channel has its own IP address and prefix length.
// - statistics counters readable singly, cleared together by a clear command.
// - unrecoverable media packet replaced by null payload and counted.
// - underrun inserts null packets, counts inserted packets and events.
// - overrun drops incoming packets, counts dropped packets and events.

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define MOGW_A_CTRL      12'h000
`define MOGW_A_STR_CFG   12'h004
`define MOGW_A_GRP1      12'h008
`define MOGW_A_SRC1      12'h00c
`define MOGW_A_GRP2      12'h010
`define MOGW_A_SRC2      12'h014
`define MOGW_A_IN_PORT   12'h018
`define MOGW_A_FEC_MAT   12'h01c
`define MOGW_A_EG_GRP    12'h020
`define MOGW_A_EG_PORTS  12'h024
`define MOGW_A_MNG_IP    12'h028
`define MOGW_A_MNG_PFX   12'h02c
`define MOGW_A_STATUS    12'h030
`define MOGW_A_CMD       12'h034
`define MOGW_A_STAT0     12'h040
// ---------------------------------------------------------------
// control bits
// ---------------------------------------------------------------
`define MOGW_B_ACTIVE    0
`define MOGW_B_ING_EN    1
`define MOGW_B_ING_FEC   2
`define MOGW_B_EG_EN     3
`define MOGW_B_EG_FEC    4
`define MOGW_B_DUAL      0
`define MOGW_B_PRI2      1
`define MOGW_B_REVERT    2
`define MOGW_B_CLR_STAT  0
`define MOGW_B_RET_PRI   1
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MOGW_R_CTRL      5'h00
`define MOGW_R_STR_CFG   3'h0
`define MOGW_R_TMO_STEPS 8'h05
`define MOGW_R_IN_PORT   16'h13c4
`define MOGW_R_FEC_LEN   5'h0a
`define MOGW_R_FEC_DEP   5'h0a
`define MOGW_R_EG_GRP    32'hef0a0a0a
`define MOGW_R_EG_PORT   16'h0400
`define MOGW_R_MNG_IP    32'hc0a80108
`define MOGW_R_MNG_PFX   6'h18
// ---------------------------------------------------------------
// limits and timing
// ---------------------------------------------------------------
`define MOGW_FEC_LEN_MIN 5'h01
`define MOGW_FEC_LEN_MAX 5'h14
`define MOGW_FEC_DEP_MIN 5'h04
`define MOGW_FEC_DEP_MAX 5'h14
`define MOGW_FEC_PROD_MAX 10'h064
`define MOGW_FEC_PORT_OFS 16'h0002
`define MOGW_CLK_HZ      10000000
`define MOGW_STEP_MS     100
`define MOGW_STEP_CYC    ((`MOGW_CLK_HZ / 1000) * `MOGW_STEP_MS)
`define MOGW_NUM_STATS   8
`endif

// ==== hw/mogw_pkg.sv ====
package mogw_pkg;
	typedef enum logic [2:0] {
		MOGW_ST_MEDIA_RX,
		MOGW_ST_RECOVERED,
		MOGW_ST_UNRECOVERED,
		MOGW_ST_DROPPED,
		MOGW_ST_NULL_UNDERRUN,
		MOGW_ST_OVERRUN_EV,
		MOGW_ST_UNDERRUN_EV,
		MOGW_ST_IGNORED
	} mogw_stat_e;
	typedef enum logic {
		MOGW_STREAM1,
		MOGW_STREAM2
	} mogw_sel_e;
	typedef logic [31:0] mogw_word_t;
endpackage

// ==== hw/mogw_stat_if.sv ====
`timescale 1ns/100ps
interface mogw_stat_if;
	logic [7:0]  inc;
	logic        clr;
	logic [2:0]  idx;
	logic [31:0] value;
	modport core (output inc, output clr, output idx, input value);
	modport bank (input inc, input clr, input idx, output value);
endinterface

// ==== hw/mogw_stat_bank.sv ====
`timescale 1ns/100ps
`include "mogw_cfg.svh"
module mogw_stat_bank (
	input wire logic    clk_sys,
	input wire logic    sys_rst,
	mogw_stat_if.bank   st
);
	import mogw_pkg::*;
	logic [31:0] cnt_ff [`MOGW_NUM_STATS];

	assign st.value = cnt_ff[st.idx];

	// clear beats a simultaneous event
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		for (int i = 0; i < `MOGW_NUM_STATS; i++) begin
			if (sys_rst)
				cnt_ff[i] <= 32'h0;
			else if (st.clr)
				cnt_ff[i] <= 32'h0;
			else if (st.inc[i])
				cnt_ff[i] <= cnt_ff[i] + 32'h1;
		end
	end
endmodule

// ==== hw/mogw_gateway.sv ====
`timescale 1ns/100ps
`include "mogw_cfg.svh"
module mogw_gateway (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [11:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic                hready,
	input  wire mogw_pkg::mogw_word_t hwdata,
	output logic [31:0]              hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// slot arbitration
	input  wire logic                second_interface_slot_en,
	// ingress from lan
	input  wire logic                ing_valid,
	input  wire logic [31:0]         ing_group,
	input  wire logic [31:0]         ing_source,
	input  wire logic [15:0]         ing_dport,
	input  wire logic                ing_bad,
	input  wire logic                ing_fec_fixable,
	input  wire logic                buf_overrun,
	input  wire logic                buf_underrun,
	input  wire logic                str1_ok,
	input  wire logic                str2_ok,
	// wan side
	output logic                     wan_valid,
	output logic                     wan_null,
	output logic                     wan_fec_bypass,
	output logic                     active_stream,
	// egress toward lan
	input  wire logic                eg_pkt_req,
	input  wire logic                eg_fec_req,
	output logic                     eg_valid,
	output logic                     eg_is_fec,
	output logic [31:0]              eg_group,
	output logic [15:0]              udp_source_port,
	output logic [15:0]              udp_destination_port,
	output logic [4:0]               fec_len,
	output logic [4:0]               fec_dep,
	// management channel
	output logic [31:0]              mng_ip,
	output logic [5:0]               mng_prefix
);
	import mogw_pkg::*;

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic fec_ok(input logic [4:0] l, input logic [4:0] d);
		logic [9:0] p;
		p = 10'(l) * 10'(d);
		return (l >= `MOGW_FEC_LEN_MIN) && (l <= `MOGW_FEC_LEN_MAX) &&
		       (d >= `MOGW_FEC_DEP_MIN) && (d <= `MOGW_FEC_DEP_MAX) &&
		       (p <= `MOGW_FEC_PROD_MAX);
	endfunction

	function automatic logic str_match(input logic [31:0] g, input logic [31:0] s,
		input logic [31:0] cg, input logic [31:0] cs);
		return (g == cg) && (s == cs);
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	localparam logic [31:0] STEP_CYC = 32'(`MOGW_STEP_CYC);

	logic [4:0]  ctrl_ff;
	logic [2:0]  str_cfg_ff;
	logic [7:0]  tmo_ff;
	logic [31:0] grp1_ff, src1_ff, grp2_ff, src2_ff;
	logic [15:0] in_port_ff;
	logic [4:0]  len_ff, dep_ff;
	logic [31:0] eg_grp_ff;
	logic [15:0] sport_ff, dport_ff;
	logic [31:0] mng_ip_ff;
	logic [5:0]  mng_pfx_ff;
	logic        fec_rej_ff;
	logic        slot_prev_ff;
	logic        fec_byp_ff;

	logic        dph_ff, dph_wr_ff;
	logic [11:0] dph_addr_ff;
	logic [31:0] hrdata_ff;

	logic        cur_ff;
	logic [31:0] step_cnt_ff;
	logic [7:0]  fail_steps_ff;

	logic        wan_valid_ff, wan_null_ff, eg_valid_ff, eg_is_fec_ff;
	logic        clr_ff;

	mogw_stat_if st ();
	mogw_stat_bank u_stat (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.st      (st)
	);

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire         addr_ph  = hsel && hready && htrans[1];
	wire         wr_go    = dph_ff && dph_wr_ff;
	wire         rd_go    = addr_ph && !hwrite;
	wire [4:0]   wl       = hwdata[4:0];
	wire [4:0]   wd       = hwdata[12:8];
	wire         fec_wr   = wr_go && dph_addr_ff == `MOGW_A_FEC_MAT;
	wire         fec_good = fec_ok(wl, wd);
	wire         cmd_wr   = wr_go && dph_addr_ff == `MOGW_A_CMD;
	wire         ctrl_wr  = wr_go && dph_addr_ff == `MOGW_A_CTRL;
	wire         slot_rise = second_interface_slot_en && !slot_prev_ff;
	wire         is_stat  = haddr[11:5] == 7'h02;

	assign st.idx = haddr[4:2];
	assign st.clr = clr_ff;

	wire [31:0] rd_val =
		(haddr == `MOGW_A_CTRL)     ? {27'h0, ctrl_ff} :
		(haddr == `MOGW_A_STR_CFG)  ? {16'h0, tmo_ff, 5'h0, str_cfg_ff} :
		(haddr == `MOGW_A_GRP1)     ? grp1_ff :
		(haddr == `MOGW_A_SRC1)     ? src1_ff :
		(haddr == `MOGW_A_GRP2)     ? grp2_ff :
		(haddr == `MOGW_A_SRC2)     ? src2_ff :
		(haddr == `MOGW_A_IN_PORT)  ? {16'h0, in_port_ff} :
		(haddr == `MOGW_A_FEC_MAT)  ? {19'h0, dep_ff, 3'h0, len_ff} :
		(haddr == `MOGW_A_EG_GRP)   ? eg_grp_ff :
		(haddr == `MOGW_A_EG_PORTS) ? {sport_ff, dport_ff} :
		(haddr == `MOGW_A_MNG_IP)   ? mng_ip_ff :
		(haddr == `MOGW_A_MNG_PFX)  ? {26'h0, mng_pfx_ff} :
		(haddr == `MOGW_A_STATUS)   ? {22'h0, fail_steps_ff, fec_rej_ff, cur_ff} :
		is_stat                     ? st.value : 32'h0;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dph_ff      <= 1'b0;
			dph_wr_ff   <= 1'b0;
			dph_addr_ff <= 12'h0;
			hrdata_ff   <= 32'h0;
		end else begin
			dph_ff      <= addr_ph;
			dph_wr_ff   <= addr_ph && hwrite;
			dph_addr_ff <= haddr;
			if (rd_go)
				hrdata_ff <= rd_val;
		end
	end

	assign hrdata    = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_ff      <= `MOGW_R_CTRL;
			slot_prev_ff <= 1'b0;
			fec_byp_ff   <= 1'b1;
		end else begin
			slot_prev_ff <= second_interface_slot_en;
			if (slot_rise) begin
				ctrl_ff[`MOGW_B_ACTIVE] <= 1'b0;
			end else if (ctrl_wr) begin
				ctrl_ff    <= hwdata[4:0];
				fec_byp_ff <= !hwdata[`MOGW_B_ING_FEC];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			str_cfg_ff <= `MOGW_R_STR_CFG;
			tmo_ff     <= `MOGW_R_TMO_STEPS;
			grp1_ff    <= 32'h0;
			src1_ff    <= 32'h0;
			grp2_ff    <= 32'h0;
			src2_ff    <= 32'h0;
			in_port_ff <= `MOGW_R_IN_PORT;
			eg_grp_ff  <= `MOGW_R_EG_GRP;
			sport_ff   <= `MOGW_R_EG_PORT;
			dport_ff   <= `MOGW_R_EG_PORT;
			mng_ip_ff  <= `MOGW_R_MNG_IP;
			mng_pfx_ff <= `MOGW_R_MNG_PFX;
		end else if (wr_go) begin
			unique case (dph_addr_ff)
				`MOGW_A_STR_CFG: begin
					str_cfg_ff <= hwdata[2:0];
					tmo_ff     <= hwdata[15:8];
				end
				`MOGW_A_GRP1:     grp1_ff    <= hwdata;
				`MOGW_A_SRC1:     src1_ff    <= hwdata;
				`MOGW_A_GRP2:     grp2_ff    <= hwdata;
				`MOGW_A_SRC2:     src2_ff    <= hwdata;
				`MOGW_A_IN_PORT:  in_port_ff <= hwdata[15:0];
				`MOGW_A_EG_GRP:   eg_grp_ff  <= hwdata;
				`MOGW_A_EG_PORTS: begin
					sport_ff <= hwdata[31:16];
					dport_ff <= hwdata[15:0];
				end
				`MOGW_A_MNG_IP:   mng_ip_ff  <= hwdata;
				`MOGW_A_MNG_PFX:  mng_pfx_ff <= hwdata[5:0];
				default: ;
			endcase
		end
	end

	// matrix only taken when within limits
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			len_ff     <= `MOGW_R_FEC_LEN;
			dep_ff     <= `MOGW_R_FEC_DEP;
			fec_rej_ff <= 1'b0;
		end else if (fec_wr) begin
			fec_rej_ff <= !fec_good;
			if (fec_good) begin
				len_ff <= wl;
				dep_ff <= wd;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			clr_ff <= 1'b0;
		else
			clr_ff <= cmd_wr && hwdata[`MOGW_B_CLR_STAT];
	end

	// ---------------------------------------------------------------
	// stream redundancy
	// ---------------------------------------------------------------
	wire dual    = str_cfg_ff[`MOGW_B_DUAL];
	wire pri     = str_cfg_ff[`MOGW_B_PRI2];
	wire revert  = str_cfg_ff[`MOGW_B_REVERT];
	wire cur_ok  = cur_ff ? str2_ok : str1_ok;
	wire oth_ok  = cur_ff ? str1_ok : str2_ok;
	wire on_pri  = cur_ff == pri;
	wire may_sw  = revert || on_pri;
	wire tmo_hit = fail_steps_ff >= tmo_ff;
	wire ret_pri = cmd_wr && hwdata[`MOGW_B_RET_PRI];
	wire step_end = step_cnt_ff == STEP_CYC - 32'h1;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cur_ff        <= 1'b0;
			step_cnt_ff   <= 32'h0;
			fail_steps_ff <= 8'h0;
		end else if (!dual || ret_pri || (wr_go && dph_addr_ff == `MOGW_A_STR_CFG)) begin
			cur_ff        <= dual ? pri : pri;
			step_cnt_ff   <= 32'h0;
			fail_steps_ff <= 8'h0;
		end else if (cur_ok) begin
			step_cnt_ff   <= 32'h0;
			fail_steps_ff <= 8'h0;
		end else if (tmo_hit && oth_ok && may_sw) begin
			cur_ff        <= !cur_ff;
			step_cnt_ff   <= 32'h0;
			fail_steps_ff <= 8'h0;
		end else if (step_end) begin
			step_cnt_ff <= 32'h0;
			if (!tmo_hit)
				fail_steps_ff <= fail_steps_ff + 8'h1;
		end else begin
			step_cnt_ff <= step_cnt_ff + 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// ingress datapath
	// ---------------------------------------------------------------
	wire ing_on   = ctrl_ff[`MOGW_B_ACTIVE] && ctrl_ff[`MOGW_B_ING_EN];
	wire fec_on   = ctrl_ff[`MOGW_B_ING_FEC];
	wire m1       = str_match(ing_group, ing_source, grp1_ff, src1_ff);
	wire m2       = str_match(ing_group, ing_source, grp2_ff, src2_ff);
	wire port_hit = ing_dport == in_port_ff;
	wire sel_hit  = port_hit && (cur_ff ? m2 : m1);
	wire ign      = ing_valid && !(port_hit && (m1 || m2));
	wire take     = ing_on && ing_valid && sel_hit && !buf_overrun;
	wire drop     = ing_on && ing_valid && sel_hit && buf_overrun;
	wire recov    = take && fec_on && ing_bad && ing_fec_fixable;
	wire unrec    = take && fec_on && ing_bad && !ing_fec_fixable;
	wire under_in = ing_on && buf_underrun && !take;
	logic over_prev_ff, under_prev_ff;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wan_valid_ff  <= 1'b0;
			wan_null_ff   <= 1'b0;
			over_prev_ff  <= 1'b0;
			under_prev_ff <= 1'b0;
		end else begin
			wan_valid_ff  <= take || under_in;
			wan_null_ff   <= unrec || under_in || (take && !fec_on && ing_bad ? 1'b0 : 1'b0);
			over_prev_ff  <= ing_on && buf_overrun;
			under_prev_ff <= ing_on && buf_underrun;
		end
	end

	assign st.inc[MOGW_ST_MEDIA_RX]     = take && fec_on;
	assign st.inc[MOGW_ST_RECOVERED]    = recov;
	assign st.inc[MOGW_ST_UNRECOVERED]  = unrec;
	assign st.inc[MOGW_ST_DROPPED]      = drop;
	assign st.inc[MOGW_ST_NULL_UNDERRUN] = under_in;
	assign st.inc[MOGW_ST_OVERRUN_EV]   = ing_on && buf_overrun && !over_prev_ff;
	assign st.inc[MOGW_ST_UNDERRUN_EV]  = ing_on && buf_underrun && !under_prev_ff;
	assign st.inc[MOGW_ST_IGNORED]      = ign;

	assign wan_valid      = wan_valid_ff;
	assign wan_null       = wan_null_ff;
	assign wan_fec_bypass = fec_byp_ff;
	assign active_stream  = cur_ff;

	// ---------------------------------------------------------------
	// egress
	// ---------------------------------------------------------------
	wire eg_on  = ctrl_ff[`MOGW_B_ACTIVE] && ctrl_ff[`MOGW_B_EG_EN];
	wire eg_fec = eg_on && ctrl_ff[`MOGW_B_EG_FEC] && eg_fec_req && !eg_pkt_req;
	logic [15:0] eg_dport_ff;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			eg_valid_ff  <= 1'b0;
			eg_is_fec_ff <= 1'b0;
			eg_dport_ff  <= `MOGW_R_EG_PORT;
		end else begin
			eg_valid_ff  <= eg_on && (eg_pkt_req || eg_fec);
			eg_is_fec_ff <= eg_fec;
			eg_dport_ff  <= eg_fec ? dport_ff + `MOGW_FEC_PORT_OFS : dport_ff;
		end
	end

	assign eg_valid             = eg_valid_ff;
	assign eg_is_fec            = eg_is_fec_ff;
	assign eg_group             = eg_grp_ff;
	assign udp_source_port      = sport_ff;
	assign udp_destination_port = eg_dport_ff;
	assign fec_len              = len_ff;
	assign fec_dep              = dep_ff;
	assign mng_ip               = mng_ip_ff;
	assign mng_prefix           = mng_pfx_ff;
endmodule

// ==== tb/mogw_lan_model.sv ====
`timescale 1ns/100ps
module mogw_lan_model (
	input  wire logic        clk_sys,
	input  wire logic        wan_valid,
	input  wire logic        wan_null,
	output logic             ing_valid,
	output logic [31:0]      ing_group,
	output logic [31:0]      ing_source,
	output logic [15:0]      ing_dport,
	output logic             ing_bad,
	output logic             ing_fec_fixable
);
	initial begin
		ing_valid = 1'b0;
		ing_group = 32'h0;
		ing_source = 32'h0;
		ing_dport = 16'h0;
		ing_bad = 1'b0;
		ing_fec_fixable = 1'b0;
	end
	// one packet; header fields scrambled once the pulse is gone
	task automatic pkt(input logic [31:0] g, input logic [31:0] s, input logic [15:0] p,
			input logic b, input logic f, output logic fw, output logic nl);
		@(posedge clk_sys);
		ing_valid <= 1'b1;
		ing_group <= g;
		ing_source <= s;
		ing_dport <= p;
		ing_bad <= b;
		ing_fec_fixable <= f;
		@(posedge clk_sys);
		ing_valid <= 1'b0;
		ing_group <= ~g;
		ing_source <= ~s;
		ing_dport <= ~p;
		ing_bad <= ~b;
		@(posedge clk_sys);
		fw = wan_valid;
		nl = wan_null;
	endtask
endmodule

// ==== tb/mogw_gateway_sva.sv ====
`timescale 1ns/100ps
module mogw_gateway_sva (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        ing_valid,
	input wire logic        buf_underrun,
	input wire logic        str1_ok,
	input wire logic        str2_ok,
	input wire logic        wan_valid,
	input wire logic        wan_null,
	input wire logic        active_stream,
	input wire logic        eg_pkt_req,
	input wire logic        eg_fec_req,
	input wire logic        eg_valid,
	input wire logic        eg_is_fec,
	input wire logic [4:0]  fec_len,
	input wire logic [4:0]  fec_dep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// cycles since last register write, saturating
	logic [2:0] wr_age_ff;
	wire        wr_seen    = hsel && hwrite && htrans[1];
	wire [2:0]  nxt_wr_age = wr_seen ? 3'h0 : wr_age_ff + {2'h0, wr_age_ff != 3'h7};
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			wr_age_ff <= 3'h0;
		else
			wr_age_ff <= nxt_wr_age;
	end
	sequence s_fec_only;
		eg_fec_req && !eg_pkt_req;
	endsequence
	sequence s_eg_grant;
		(eg_pkt_req || eg_fec_req) ##1 eg_valid;
	endsequence
	a_media_needs_req: assert property (eg_valid && !eg_is_fec |-> $past(eg_pkt_req))
		else $error("media packet without request");
	a_fec_only_fec: assert property (s_fec_only |=> !eg_valid || eg_is_fec)
		else $error("fec request produced media packet");
	a_media_wins: assert property (eg_pkt_req |=> !(eg_valid && eg_is_fec))
		else $error("fec granted over media request");
	a_fec_dims_legal: assert property (fec_len >= 5'h01 && fec_len <= 5'h14
		&& fec_dep >= 5'h04 && fec_dep <= 5'h14) else $error("fec matrix size out of range");
	a_fec_prod_legal: assert property ((10'(fec_len) * 10'(fec_dep)) <= 10'h064)
		else $error("fec matrix product above limit");
	a_null_is_valid: assert property (wan_null |-> wan_valid)
		else $error("null payload without wan packet");
	a_wan_has_cause: assert property (wan_valid |-> $past(ing_valid) || $past(buf_underrun)
		|| $past(buf_underrun, 2)) else $error("wan packet without cause");
	a_switch_on_fail: assert property ($changed(active_stream) |-> wr_age_ff <= 3'h4
		|| $past(active_stream ? !str2_ok : !str1_ok)) else $error("stream switch without failure");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or error");
	c_eg_grant: cover property (s_eg_grant);
endmodule
bind mogw_gateway mogw_gateway_sva u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
	.ing_valid(ing_valid), .buf_underrun(buf_underrun), .str1_ok(str1_ok), .str2_ok(str2_ok),
	.wan_valid(wan_valid), .wan_null(wan_null), .active_stream(active_stream),
	.eg_pkt_req(eg_pkt_req), .eg_fec_req(eg_fec_req), .eg_valid(eg_valid),
	.eg_is_fec(eg_is_fec), .fec_len(fec_len), .fec_dep(fec_dep));

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`include "mogw_cfg.svh"
module testbench;
	import mogw_pkg::*;
	logic        clk_sys, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, q, ing_group, ing_source, eg_group, mng_ip;
	logic        second_interface_slot_en, ing_valid, ing_bad, ing_fec_fixable, buf_overrun;
	logic        buf_underrun, str1_ok, str2_ok, wan_valid, wan_null, wan_fec_bypass, fw, nl;
	logic        active_stream, eg_pkt_req, eg_fec_req, eg_valid, eg_is_fec;
	logic [15:0] ing_dport, udp_source_port, udp_destination_port;
	logic [4:0]  fec_len, fec_dep, el, ed;
	logic [5:0]  mng_prefix;
	int          n_fail, cmp_count, cyc;
	logic [4:0]  fl[8] = '{5'h14, 5'h15, 5'h00, 5'h14, 5'h01, 5'h04, 5'h05, 5'h04};
	logic [4:0]  fd[8] = '{5'h05, 5'h04, 5'h04, 5'h06, 5'h04, 5'h03, 5'h14, 5'h15};
	logic        fok[8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	assign hready = hreadyout;
	mogw_gateway dut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
		.hwdata, .hrdata, .hreadyout, .hresp, .second_interface_slot_en, .ing_valid, .ing_group,
		.ing_source, .ing_dport, .ing_bad, .ing_fec_fixable, .buf_overrun, .buf_underrun,
		.str1_ok, .str2_ok, .wan_valid, .wan_null, .wan_fec_bypass, .active_stream, .eg_pkt_req,
		.eg_fec_req, .eg_valid, .eg_is_fec, .eg_group, .udp_source_port, .udp_destination_port,
		.fec_len, .fec_dep, .mng_ip, .mng_prefix);
	mogw_lan_model lan (.clk_sys, .wan_valid, .wan_null, .ing_valid, .ing_group, .ing_source,
		.ing_dport, .ing_bad, .ing_fec_fixable);
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rdm(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(a, 1'b0, 32'h0);
		chk(q & m, e);
	endtask
	// egress request pulse, result {valid, is_fec, port}
	task automatic eg(input logic p, input logic f, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk_sys);
		eg_pkt_req <= p;
		eg_fec_req <= f;
		@(posedge clk_sys);
		eg_pkt_req <= 1'b0;
		eg_fec_req <= 1'b0;
		@(posedge clk_sys);
		chk({14'h0, eg_valid, eg_is_fec, udp_destination_port} & m, e);
	endtask
	task automatic strm(input logic e, input logic hold);
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (!hold && active_stream === e)
				break;
		end
		chk({31'h0, active_stream}, {31'h0, e});
	endtask
	task automatic ing(input logic [31:0] g, input logic [15:0] p, input logic b, input logic f,
			input logic efw, input logic enl);
		lan.pkt(g, {g[31:8], 8'h01}, p, b, f, fw, nl);
		chk({30'h0, fw, nl}, {30'h0, efw, enl});
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{hsel, hwrite, haddr, htrans, hwdata, second_interface_slot_en} = '0;
		{buf_overrun, buf_underrun, eg_pkt_req, eg_fec_req, n_fail, cmp_count, cyc} = '0;
		{str1_ok, str2_ok, hsize, sys_rst} = {2'h3, 3'h2, 1'b1};
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdm(`MOGW_A_EG_GRP, 32'hef0a0a0a);
		rdm(`MOGW_A_EG_PORTS, 32'h04000400);
		rdm(`MOGW_A_MNG_IP, 32'hc0a80108);
		rdm(`MOGW_A_MNG_PFX, 32'h18);
		rdm(`MOGW_A_FEC_MAT, 32'h0a0a);
		rdm(`MOGW_A_IN_PORT, 32'h13c4);
		rdm(12'h3fc, 32'h0);
		$display("test reset values done");
		{el, ed} = {5'h0a, 5'h0a};
		for (int i = 0; i < 8; i++) begin
			wr(`MOGW_A_FEC_MAT, {19'h0, fd[i], 3'h0, fl[i]});
			if (fok[i])
				{el, ed} = {fl[i], fd[i]};
			else
				rdm(`MOGW_A_STATUS, 32'h2, 32'h2);
			rdm(`MOGW_A_FEC_MAT, {19'h0, ed, 3'h0, el});
			chk({22'h0, fec_len, fec_dep}, {22'h0, el, ed});
		end
		$display("test fec matrix done");
		wr(`MOGW_A_EG_PORTS, 32'h12345678);
		wr(`MOGW_A_EG_GRP, 32'hef010203);
		wr(`MOGW_A_CTRL, 32'h09);
		chk(eg_group, 32'hef010203);
		chk({16'h0, udp_source_port}, 32'h1234);
		eg(1'b1, 1'b0, 32'h25678, 32'h3ffff);
		eg(1'b0, 1'b1, 32'h0, 32'h20000);
		wr(`MOGW_A_CTRL, 32'h19);
		eg(1'b0, 1'b1, 32'h3567a, 32'h3ffff);
		eg(1'b1, 1'b1, 32'h25678, 32'h3ffff);
		wr(`MOGW_A_CTRL, 32'h01);
		eg(1'b1, 1'b0, 32'h0, 32'h20000);
		wr(`MOGW_A_MNG_IP, 32'h0a000005);
		wr(`MOGW_A_MNG_PFX, 32'h10);
		rdm(`MOGW_A_MNG_PFX, 32'h10);
		chk(mng_ip, 32'h0a000005);
		chk({26'h0, mng_prefix}, 32'h10);
		$display("test egress done");
		wr(`MOGW_A_GRP1, 32'hef010101);
		wr(`MOGW_A_SRC1, 32'hef010101);
		wr(`MOGW_A_GRP2, 32'hef020202);
		wr(`MOGW_A_SRC2, 32'hef020201);
		wr(`MOGW_A_SRC1, 32'hef010101 & 32'hffffff01);
		wr(`MOGW_A_CTRL, 32'h07);
		@(posedge clk_sys);
		chk({31'h0, wan_fec_bypass}, 32'h0);
		ing(32'hef010101, 16'h13c4, 1'b0, 1'b0, 1'b1, 1'b0);
		ing(32'hef010101, 16'h13c5, 1'b0, 1'b0, 1'b0, 1'b0);
		ing(32'hef010101, 16'h13c4, 1'b1, 1'b0, 1'b1, 1'b1);
		ing(32'hef010101, 16'h13c4, 1'b1, 1'b1, 1'b1, 1'b0);
		buf_overrun <= 1'b1;
		ing(32'hef010101, 16'h13c4, 1'b0, 1'b0, 1'b0, 1'b0);
		buf_overrun <= 1'b0;
		@(posedge clk_sys);
		buf_underrun <= 1'b1;
		@(posedge clk_sys);
		buf_underrun <= 1'b0;
		@(posedge clk_sys);
		chk({31'h0, wan_null}, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h08, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h0c, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h14, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h18, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h1c, 32'h1);
		rdm(`MOGW_A_STAT0, 32'h3);
		rdm(`MOGW_A_STAT0 + 12'h04, 32'h1);
		rdm(`MOGW_A_STAT0 + 12'h10, 32'h1);
		wr(`MOGW_A_CMD, 32'h1);
		for (int i = 0; i < 8; i++)
			rdm(`MOGW_A_STAT0 + 12'(4 * i), 32'h0);
		ing(32'hef020202, 16'h13c4, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(`MOGW_A_CTRL, 32'h03);
		@(posedge clk_sys);
		chk({31'h0, wan_fec_bypass}, 32'h1);
		wr(`MOGW_A_CTRL, 32'h01);
		ing(32'hef010101, 16'h13c4, 1'b0, 1'b0, 1'b0, 1'b0);
		$display("test ingress done");
		wr(`MOGW_A_STR_CFG, 32'h05);
		strm(1'b0, 1'b1);
		str1_ok <= 1'b0;
		strm(1'b1, 1'b0);
		{str1_ok, str2_ok} <= 2'b10;
		strm(1'b0, 1'b0);
		str2_ok <= 1'b1;
		wr(`MOGW_A_STR_CFG, 32'h01);
		str1_ok <= 1'b0;
		strm(1'b1, 1'b0);
		{str1_ok, str2_ok} <= 2'b10;
		strm(1'b1, 1'b1);
		wr(`MOGW_A_CMD, 32'h2);
		strm(1'b0, 1'b0);
		str2_ok <= 1'b1;
		wr(`MOGW_A_STR_CFG, 32'h02);
		strm(1'b1, 1'b0);
		str2_ok <= 1'b0;
		strm(1'b1, 1'b1);
		str2_ok <= 1'b1;
		$display("test redundancy done");
		second_interface_slot_en <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rdm(`MOGW_A_CTRL, 32'h0, 32'h1);
		second_interface_slot_en <= 1'b0;
		$display("test slot arbitration done");
		final_report();
	end
endmodule
